/* pkg/ftc_pkg.sv */
// Shared constants and types for the frame timestamp codec.
package ftc_pkg;
  localparam int TS_W = 24;
  localparam logic [23:0] TS_MAX_VALID = 24'hF9_FFFF;
  localparam logic [23:0] TS_NULL = 24'hFF_FFFF;
  localparam logic [23:0] TS_RSV_LO = 24'hFA_0000;
  localparam logic [6:0] LVL1_MAX = 7'h7C;
  localparam logic [6:0] LVL1_ALT = 7'h7F;
  // Level field positions, counted from the least significant bit.
  localparam int LVL1_LSB = 17;
  localparam int LVL2_LSB = 14;
  localparam int LVL3_LSB = 6;
  localparam int LVL4_LSB = 3;
  localparam int LVL5_LSB = 0;
  localparam logic [7:0] TS_FILL_BYTE = 8'hFF;
  localparam int TS_TRAILER_BYTES = 4;
  localparam int SIG_GROUPS = 3;
  localparam int SIG_BLOCKS = 8;
  localparam logic [2:0] LEVEL_MIN = 3'h1;
  localparam logic [2:0] LEVEL_MAX = 3'h5;
  localparam logic [2:0] LEVEL_DEFAULT = 3'h2;
  localparam logic [23:0] TICK_ZERO = 24'h00_0000;
  typedef enum logic [1:0] {TS_ORDINARY, TS_NULLCODE, TS_RESERVED, TS_BADLEVEL} ftc_class_t;

  // Keeps levels 1..lvl and zeroes finer ones (lvl 0, 6 or 7 keeps all five); null code passes unchanged.
  function automatic logic [23:0] ftc_trim(input logic [23:0] ts, input logic [2:0] lvl);
    logic [23:0] m;
    m = 24'h00_0000;
    case (lvl)
      3'h1: m = 24'hFE_0000;
      3'h2: m = 24'hFF_C000;
      3'h3: m = 24'hFF_FFC0;
      3'h4: m = 24'hFF_FFF8;
      default: m = 24'hFF_FFFF;
    endcase
    ftc_trim = (ts == TS_NULL) ? TS_NULL : (ts & m);
  endfunction

  // Classifies a 24-bit value by range and level-one field.
  function automatic ftc_class_t ftc_classify(input logic [23:0] ts);
    logic [6:0] l1;
    l1 = ts[23:17];
    if (ts == TS_NULL) begin
      ftc_classify = TS_NULLCODE;
    end else if (ts >= TS_RSV_LO) begin
      ftc_classify = TS_RESERVED;
    end else if (l1 > LVL1_MAX && l1 != LVL1_ALT) begin
      ftc_classify = TS_BADLEVEL;
    end else begin
      ftc_classify = TS_ORDINARY;
    end
  endfunction
endpackage

/* pkg/ftc_link_if.sv */
// Interface joining the timestamp generator to the consuming multiplexer.
`timescale 1ns/1ps
interface ftc_link_if;
  logic frame_valid;
  logic frame_ready;
  logic [7:0] trailer_byte [4];
  logic [7:0] sig_bit5 [3];
  logic [23:0] ts_word;
  logic ref_pulse;
  modport gen (output frame_valid, output trailer_byte, output sig_bit5, output ts_word, input frame_ready,
    input ref_pulse);
  modport mux (input frame_valid, input trailer_byte, input sig_bit5, input ts_word, output frame_ready,
    output ref_pulse);
endinterface

/* core/ftc_generator.sv */
// Generator end: encodes, trims and places the frame timestamp.
`timescale 1ns/1ps
// Functional notes
// - Timestamp is 24-bit count of 16.384 MHz ticks.
// - Five level fields, widths 7,3,8,3,3.
// - Ordinary values lie in 0 to F9FFFF.
// - All ones means no timing information.
// - FA0000 to FFFFFE reserved, never emitted.
// - Unused finer levels are cleared to zero.
// - Default fill is levels one and two.
// - Trailer bytes: FF, then bits 16-23, 8-15, 0-7.
// - Signalling bit 5 carries bit 8s plus block.
// - Timestamp marks the first bit's transmission instant.
// - Offset counts from shared reference pulse.
// - Provider uses timestamp to absorb transit delay.
// - Physical timestamp marks converter output instant.
module ftc_generator
  import ftc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  ftc_link_if.gen LINK,
  input wire logic FRAME_REQ,
  input wire logic [23:0] FRAME_TIME,
  input wire logic FRAME_NULL,
  input wire logic [2:0] FRAME_LEVEL,
  output logic FRAME_BUSY,
  output logic FRAME_REJECT
);
  // Handshake state: one frame stands on the link until the consumer takes it.
  logic valid_reg, valid_next;
  logic busy_reg, busy_next;
  logic reject_reg, reject_next;

  // The stored word and its two placements on the link.
  logic [23:0] ts_reg, ts_next;
  logic [7:0] tb_reg [4];
  logic [7:0] tb_next [4];
  logic [7:0] sig_reg [3];
  logic [7:0] sig_next [3];

  // Request decoding, shared by every state group.
  logic [23:0] candidate;
  logic [2:0] level_eff;
  logic request_seen;
  logic request_ok;
  logic request_bad;
  logic handed_over;
  logic [2:0][7:0] place_byte;
  logic [2:0][7:0] place_bits;
  ftc_class_t cls;

  // Levels outside one to five are not an error: they fall back to the recommended setting.
  function automatic logic [2:0] ftc_pick_level(input logic [2:0] lvl);
    if (lvl < LEVEL_MIN || lvl > LEVEL_MAX) begin
      ftc_pick_level = LEVEL_DEFAULT;
    end else begin
      ftc_pick_level = lvl;
    end
  endfunction

  // Only ordinary and null words may leave; everything else is refused.
  function automatic logic ftc_sendable(input ftc_class_t c);
    ftc_sendable = (c == TS_ORDINARY) || (c == TS_NULLCODE);
  endfunction

  // Trimming runs before the range check, so the check sees exactly the word that would be sent.
  always_comb begin
    level_eff = ftc_pick_level(FRAME_LEVEL);
    if (FRAME_NULL) begin
      candidate = TS_NULL;
    end else begin
      candidate = ftc_trim(FRAME_TIME, level_eff);
    end
    cls = ftc_classify(candidate);
  end

  // A request counts only while no frame is held; later ones are dropped without a word.
  always_comb begin
    request_seen = FRAME_REQ && !busy_reg;
    request_ok = request_seen && ftc_sendable(cls);
    request_bad = request_seen && !ftc_sendable(cls);
    handed_over = valid_reg && LINK.frame_ready;
  end

  // Hand-over and a new frame never meet in one cycle, since requests are taken only while idle.
  always_comb begin
    valid_next = valid_reg;
    busy_next = busy_reg;
    reject_next = 1'b0;
    if (handed_over) begin
      valid_next = 1'b0;
      busy_next = 1'b0;
    end
    if (request_ok) begin
      valid_next = 1'b1;
      busy_next = 1'b1;
    end
    if (request_bad) begin
      reject_next = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      busy_reg <= busy_next;
      reject_reg <= reject_next;
    end
  end

  // The word stays after hand-over, so a consumer that looks late still sees the last frame.
  always_comb begin
    ts_next = ts_reg;
    if (request_ok) begin
      ts_next = candidate;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ts_reg <= TS_NULL;
    end else begin
      ts_reg <= ts_next;
    end
  end

  // Group g carries the g-th most significant byte twice: whole in the trailer and bit by bit in
  // the signalling bytes, block bl holding bit 8g+bl counted from the most significant end.
  for (genvar g = 0; g < SIG_GROUPS; g++) begin : g_place
    assign place_byte[g] = candidate[23 - 8 * g -: 8];
    for (genvar b = 0; b < SIG_BLOCKS; b++) begin : g_block
      assign place_bits[g][b] = candidate[23 - 8 * g - b];
    end
  end

  always_comb begin
    tb_next = tb_reg;
    if (request_ok) begin
      tb_next[0] = TS_FILL_BYTE;
      for (int i = 0; i < SIG_GROUPS; i++) begin
        tb_next[i + 1] = place_byte[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < TS_TRAILER_BYTES; i++) begin
        tb_reg[i] <= TS_FILL_BYTE;
      end
    end else begin
      tb_reg <= tb_next;
    end
  end

  always_comb begin
    sig_next = sig_reg;
    if (request_ok) begin
      for (int i = 0; i < SIG_GROUPS; i++) begin
        sig_next[i] = place_bits[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < SIG_GROUPS; i++) begin
        sig_reg[i] <= TS_FILL_BYTE;
      end
    end else begin
      sig_reg <= sig_next;
    end
  end

  // Every link output comes straight from a register, so the consumer never sees decode glitches.
  assign LINK.frame_valid = valid_reg;
  assign LINK.ts_word = ts_reg;
  assign LINK.trailer_byte = tb_reg;
  assign LINK.sig_bit5 = sig_reg;
  assign FRAME_BUSY = busy_reg;
  assign FRAME_REJECT = reject_reg;
endmodule // ftc_generator

/* core/ftc_receiver.sv */
// Consumer end: validates the timestamp and releases the frame on time.
`timescale 1ns/1ps
module ftc_receiver
  import ftc_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  ftc_link_if.mux LINK,
  input wire logic REF_PULSE_IN,
  output logic REF_PULSE,
  output logic RELEASE,
  output logic [23:0] RELEASE_TIME,
  output logic NO_TIMING,
  output logic TS_INVALID
);
  logic ref_meta_reg, ref_sync_reg, ref_prev_reg;
  logic [23:0] tick_reg, tick_next;
  logic hold_reg, hold_next;
  logic [23:0] due_reg, due_next;
  logic release_reg, release_next;
  logic [23:0] rtime_reg, rtime_next;
  logic notime_reg, notime_next;
  logic inval_reg, inval_next;
  logic ref_rise;
  ftc_class_t cls;

  always_comb begin
    ref_rise = ref_sync_reg && !ref_prev_reg;
    // The tick count restarts on every rising reference edge; it is the offset base.
    tick_next = ref_rise ? TICK_ZERO : tick_reg + 24'h00_0001;
    cls = ftc_classify(LINK.ts_word);
    hold_next = hold_reg;
    due_next = due_reg;
    release_next = 1'b0;
    rtime_next = rtime_reg;
    notime_next = notime_reg;
    inval_next = inval_reg;
    // In the cycle of the release pulse the generator still shows the frame just taken; taking
    // it again would release one frame twice and pair the next one with the wrong pulse.
    if (!hold_reg && !release_reg && LINK.frame_valid) begin
      hold_next = 1'b1;
      due_next = LINK.ts_word;
      notime_next = (cls == TS_NULLCODE);
      inval_next = (cls == TS_RESERVED || cls == TS_BADLEVEL);
    end else if (hold_reg) begin
      // Frames without usable timing go out at once instead of waiting.
      if (notime_reg || inval_reg || tick_reg == due_reg) begin
        hold_next = 1'b0;
        release_next = 1'b1;
        rtime_next = tick_reg;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      tick_reg <= TICK_ZERO;
      hold_reg <= 1'b0;
      due_reg <= TICK_ZERO;
      release_reg <= 1'b0;
      rtime_reg <= TICK_ZERO;
      notime_reg <= 1'b0;
      inval_reg <= 1'b0;
    end else begin
      ref_meta_reg <= REF_PULSE_IN;
      ref_sync_reg <= ref_meta_reg;
      ref_prev_reg <= ref_sync_reg;
      tick_reg <= tick_next;
      hold_reg <= hold_next;
      due_reg <= due_next;
      release_reg <= release_next;
      rtime_reg <= rtime_next;
      notime_reg <= notime_next;
      inval_reg <= inval_next;
    end
  end

  assign LINK.frame_ready = release_reg;
  assign LINK.ref_pulse = ref_prev_reg;
  assign REF_PULSE = ref_prev_reg;
  assign RELEASE = release_reg;
  assign RELEASE_TIME = rtime_reg;
  assign NO_TIMING = notime_reg;
  assign TS_INVALID = inval_reg;
endmodule // ftc_receiver

/* test/ftc_link_properties.sv */
// Link checks between the timestamp generator and the consumer.
`timescale 1ns/1ps
module ftc_link_properties (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic frame_valid,
  input wire logic frame_ready,
  input wire logic [7:0] trailer_byte [4],
  input wire logic [7:0] sig_bit5 [3],
  input wire logic [23:0] ts_word
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  sequence s_wait;
    frame_valid && !frame_ready;
  endsequence
  sequence s_held;
    frame_valid && $stable(ts_word);
  endsequence
  property p_hold;
    s_wait |=> s_held;
  endproperty
  a_hold: assert property (p_hold) else $error("frame lost before acceptance");
  property p_drop;
    frame_valid && frame_ready |=> !frame_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("frame kept after acceptance");
  property p_ready_pulse;
    frame_ready |=> !frame_ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("release pulse longer than one cycle");
  property p_fill;
    frame_valid |-> trailer_byte[0] == 8'hFF;
  endproperty
  a_fill: assert property (p_fill) else $error("bad fill byte");
  property p_hi;
    frame_valid |-> trailer_byte[1] == ts_word[23:16];
  endproperty
  a_hi: assert property (p_hi) else $error("bad high trailer byte");
  property p_lo;
    frame_valid |-> {trailer_byte[2], trailer_byte[3]} == ts_word[15:0];
  endproperty
  a_lo: assert property (p_lo) else $error("bad low trailer bytes");
  property p_sig_a;
    frame_valid |-> sig_bit5[0][0] == ts_word[23] && sig_bit5[1][0] == ts_word[15];
  endproperty
  a_sig_a: assert property (p_sig_a) else $error("bad first signalling bit");
  property p_sig_b;
    frame_valid |-> sig_bit5[2][7] == ts_word[0] && sig_bit5[0][7] == ts_word[16];
  endproperty
  a_sig_b: assert property (p_sig_b) else $error("bad last signalling bit");
  property p_range;
    frame_valid |-> ts_word <= 24'hF9_FFFF || ts_word == 24'hFF_FFFF;
  endproperty
  a_range: assert property (p_range) else $error("reserved value sent");
  property p_lvl1;
    frame_valid && ts_word != 24'hFF_FFFF |-> ts_word[23:17] <= 7'h7C;
  endproperty
  a_lvl1: assert property (p_lvl1) else $error("bad level one field");
endmodule // ftc_link_properties

/* test/frame_timestamp_codec_tb_top.sv */
// Bench joining generator and consumer over the link.
`timescale 1ns/1ps
module frame_timestamp_codec_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req = 1'b0;
  logic [23:0] ftime = 24'h00_0000;
  logic fnull = 1'b0;
  logic [2:0] flevel = 3'h0;
  logic ref_in = 1'b0;
  logic busy, reject, ref_out, rel, no_timing, ts_invalid;
  logic [23:0] rel_time;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  ftc_link_if link ();
  ftc_generator ftc_generator_inst (.CORE_CLK(clk), .RESET(reset), .LINK(link), .FRAME_REQ(req),
    .FRAME_TIME(ftime), .FRAME_NULL(fnull), .FRAME_LEVEL(flevel), .FRAME_BUSY(busy), .FRAME_REJECT(reject));
  ftc_receiver ftc_receiver_inst (.CORE_CLK(clk), .RESET(reset), .LINK(link), .REF_PULSE_IN(ref_in),
    .REF_PULSE(ref_out), .RELEASE(rel), .RELEASE_TIME(rel_time), .NO_TIMING(no_timing), .TS_INVALID(ts_invalid));
  ftc_link_properties ftc_link_properties_inst (.CORE_CLK(clk), .RESET(reset), .frame_valid(link.frame_valid),
    .frame_ready(link.frame_ready), .trailer_byte(link.trailer_byte), .sig_bit5(link.sig_bit5), .ts_word(link.ts_word));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic send(input logic [23:0] t, input logic [2:0] lv, input logic nl);
    @(negedge clk);
    ftime = t;
    flevel = lv;
    fnull = nl;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask
  task automatic place(input logic [23:0] e);
    logic [23:0] r;
    logic [31:0] t;
    r = {<<{e}};
    @(negedge clk);
    t = {link.trailer_byte[0], link.trailer_byte[1], link.trailer_byte[2], link.trailer_byte[3]};
    chk("valid", link.frame_valid, 1'b1);
    chk("busy", busy, 1'b1);
    chk("ts_word", link.ts_word, e);
    chk("trailer", t, {8'hFF, e});
    chk("sig_bit5", {link.sig_bit5[2], link.sig_bit5[1], link.sig_bit5[0]}, r);
  endtask
  // Waits for the release; an ordinary frame needs a reference pulse to restart the tick.
  task automatic deliver(input logic [23:0] e, input logic nl);
    int n;
    n = 0;
    place(e);
    if (!nl) begin
      ref_in = 1'b1;
      @(negedge clk);
      ref_in = 1'b0;
      repeat (2) @(negedge clk);
      chk("ref_pulse", ref_out, 1'b1);
    end
    while (rel !== 1'b1 && n < 800) begin
      @(negedge clk);
      n++;
    end
    chk("release", {rel, no_timing}, {1'b1, nl});
    chk("ts_invalid", ts_invalid, 1'b0);
    if (!nl) begin
      chk("release_time", rel_time, e);
    end
  endtask
  task automatic test_trim();
    send(24'h01_FFFF, 3'h1, 1'b0);
    deliver(24'h00_0000, 1'b0);
    send(24'h00_3FFF, 3'h2, 1'b0);
    deliver(24'h00_0000, 1'b0);
    send(24'h00_3FFF, 3'h0, 1'b0);
    deliver(24'h00_0000, 1'b0);
    send(24'h00_00FF, 3'h3, 1'b0);
    deliver(24'h00_00C0, 1'b0);
    send(24'h00_01FF, 3'h4, 1'b0);
    deliver(24'h00_01F8, 1'b0);
    $display("trim test done");
  endtask
  task automatic test_place();
    send(24'h5A_C3A5, 3'h5, 1'b0);
    place(24'h5A_C3A5);
    reset = 1'b1;
    @(negedge clk);
    chk("reset", {link.frame_valid, busy, link.ts_word}, {1'b0, 1'b0, 24'hFF_FFFF});
    reset = 1'b0;
    $display("placement test done");
  endtask
  task automatic test_null();
    send(24'h12_3456, 3'h5, 1'b1);
    deliver(24'hFF_FFFF, 1'b1);
    $display("null test done");
  endtask
  task automatic test_reserved();
    send(24'hFA_0000, 3'h5, 1'b0);
    chk("reject", {reject, link.frame_valid}, {1'b1, 1'b0});
    @(negedge clk);
    chk("reject_drop", {reject, busy, link.frame_valid}, 3'b000);
    $display("reserved test done");
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    test_trim();
    test_place();
    test_null();
    test_reserved();
    final_report();
  end
endmodule // frame_timestamp_codec_tb_top
